/* File: core/csf_core_regs.sv */
// Purpose: stack pointers, static base, flag register and general register banks
// Assumes: APB slave for software, a direct port for the ALU and the core
// Notes:   core writes win over bus writes to the same storage
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] two 16-bit stack pointers, one user and one interrupt
// [RULE2] stack select flag picks which pointer acts as the active pointer
// [RULE3] a 16-bit static base register is held and driven to the core
// [RULE4] flag register is 11 bits and shows the present core state
// [RULE5] carry flag takes the carry, borrow or shift-out from the ALU
// [RULE6] software keeps the debug flag at zero; hardware only stores it
// [RULE7] zero flag is 1 for a zero result, else 0
// [RULE8] sign flag is 1 for a negative result, else 0
// [RULE9] bank flag 0 routes register access to bank 0, 1 to bank 1
// [RULE10] overflow flag is 1 when the operation overflows, else 0
// [RULE11] each bank holds four data, two address and one frame base register
// [RULE12] stack select 0 picks the interrupt pointer, 1 the user pointer
module csf_core_regs
	import csf_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 alu_flag_we,
	input  wire logic [WIDTH-1:0]     alu_result,
	input  wire logic                 alu_carry,
	input  wire logic                 alu_overflow,
	input  wire logic                 sp_we,
	input  wire logic [WIDTH-1:0]     sp_wdata,
	output logic      [WIDTH-1:0]     active_stack_ptr,
	output logic      [WIDTH-1:0]     static_base_reg,
	output logic      [FLAG_W-1:0]    processor_flag_reg,
	input  wire logic [GPR_IDX_W-1:0] gpr_idx,
	input  wire logic                 gpr_we,
	input  wire logic [WIDTH-1:0]     gpr_wdata,
	output logic      [WIDTH-1:0]     gpr_rdata
);

	// ========================================================================
	// checks
	if (WIDTH != DATA_W) begin : g_bad_width
		$error("csf_core_regs: WIDTH must equal the 16-bit register width");
	end

	// ========================================================================
	// address decode
	function automatic csf_sel_t decode_sel(input logic [ADDR_W-1:0] addr);
		csf_sel_t sel;
		sel = CSF_SEL_NONE;
		if (addr == OFS_USP) begin
			sel = CSF_SEL_USP;
		end else if (addr == OFS_ISP) begin
			sel = CSF_SEL_ISP;
		end else if (addr == OFS_SB) begin
			sel = CSF_SEL_SB;
		end else if (addr == OFS_FLG) begin
			sel = CSF_SEL_FLG;
		end else if (addr == OFS_ASP) begin
			sel = CSF_SEL_ASP;
		end else if (addr[1:0] == 2'h0 && (addr[11:5] == OFS_BANK0[11:5]
				|| addr[11:5] == OFS_BANK1[11:5]) && addr[4:2] < 3'(BANK_REGS)) begin
			sel = CSF_SEL_BANK;
		end
		return sel;
	endfunction

	// bank word address: bank number on top, register index below
	function automatic logic [MEM_AW-1:0] mem_addr(input logic bank,
			input logic [GPR_IDX_W-1:0] idx);
		return {bank, idx};
	endfunction

	// ========================================================================
	// declarations
	csf_sel_t          sel;
	logic              acc;
	logic              bus_wr;
	logic              core_gpr_wr;
	logic              bank_wr_stall;
	logic              bus_bank;
	logic [WIDTH-1:0]  usp_q;
	logic [WIDTH-1:0]  usp_d;
	logic [WIDTH-1:0]  isp_q;
	logic [WIDTH-1:0]  isp_d;
	logic [WIDTH-1:0]  sb_q;
	logic [WIDTH-1:0]  sb_d;
	logic [FLAG_W-1:0] flg_q;
	logic [FLAG_W-1:0] flg_d;
	logic [WIDTH-1:0]  asp_q;
	logic [WIDTH-1:0]  asp_d;
	logic              mem_we;
	logic [MEM_AW-1:0] mem_waddr;
	logic [WIDTH-1:0]  mem_wdata;
	logic [WIDTH-1:0]  mem_rd_core;
	logic [WIDTH-1:0]  mem_rd_bus;

	// ========================================================================
	// bus handshake
	assign sel           = decode_sel(paddr);
	assign acc           = psel && penable;
	assign bus_bank      = (paddr[11:5] == OFS_BANK1[11:5]);
	assign core_gpr_wr   = gpr_we && (gpr_idx < 3'(BANK_REGS));          // [RULE11]
	// a bank write from the bus waits while the core owns the write port
	assign bank_wr_stall = (sel == CSF_SEL_BANK) && pwrite && core_gpr_wr;
	assign pready        = !bank_wr_stall;
	assign pslverr       = acc && pready
		&& ((sel == CSF_SEL_NONE) || ((sel == CSF_SEL_ASP) && pwrite));
	assign bus_wr        = acc && pready && pwrite && !pslverr;

	// ========================================================================
	// stack pointers and static base
	always_comb begin
		usp_d = usp_q;
		isp_d = isp_q;
		sb_d  = sb_q;
		if (bus_wr && sel == CSF_SEL_USP) begin
			usp_d = pwdata[WIDTH-1:0];                                    // [RULE1]
		end
		if (bus_wr && sel == CSF_SEL_ISP) begin
			isp_d = pwdata[WIDTH-1:0];                                    // [RULE1]
		end
		if (bus_wr && sel == CSF_SEL_SB) begin
			sb_d = pwdata[WIDTH-1:0];                                     // [RULE3]
		end
		// a core stack write lands in whichever pointer is active now
		if (sp_we) begin
			if (flg_q[FLG_U]) begin                                       // [RULE12]
				usp_d = sp_wdata;                                         // [RULE2]
			end else begin
				isp_d = sp_wdata;                                         // [RULE2]
			end
		end
		// active pointer follows the select bit as it will stand next cycle
		asp_d = flg_d[FLG_U] ? usp_d : isp_d;                             // [RULE2] [RULE12]
	end

	// ========================================================================
	// flag register
	csf_flag_unit #(
		.WIDTH        (WIDTH)
	) u_flag (
		.flag_q       (flg_q),
		.sw_we        (bus_wr && sel == CSF_SEL_FLG),
		.sw_wdata     (pwdata[FLAG_W-1:0]),                               // [RULE6]
		.alu_flag_we  (alu_flag_we),
		.alu_result   (alu_result),
		.alu_carry    (alu_carry),
		.alu_overflow (alu_overflow),
		.flag_d       (flg_d)                                             // [RULE4]
	);

	// ========================================================================
	// state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			usp_q <= RST_USP;
			isp_q <= RST_ISP;
			sb_q  <= RST_SB;
			flg_q <= RST_FLG;
			asp_q <= RST_ISP;
		end else begin
			usp_q <= usp_d;
			isp_q <= isp_d;
			sb_q  <= sb_d;
			flg_q <= flg_d;
			asp_q <= asp_d;
		end
	end

	assign active_stack_ptr   = asp_q;
	assign static_base_reg    = sb_q;                                     // [RULE3]
	assign processor_flag_reg = flg_q;                                    // [RULE4]

	// ========================================================================
	// general register banks
	always_comb begin
		mem_we    = 1'b0;
		mem_waddr = '0;
		mem_wdata = '0;
		if (core_gpr_wr) begin
			mem_we    = 1'b1;
			mem_waddr = mem_addr(flg_q[FLG_B], gpr_idx);                  // [RULE9]
			mem_wdata = gpr_wdata;
		end else if (bus_wr && sel == CSF_SEL_BANK) begin
			mem_we    = 1'b1;
			mem_waddr = mem_addr(bus_bank, paddr[4:2]);
			mem_wdata = pwdata[WIDTH-1:0];
		end
	end

	csf_bank_mem #(
		.WIDTH     (WIDTH),
		.AW        (MEM_AW)
	) u_bank (
		.pclk      (pclk),
		.presetn   (presetn),
		.wr_en     (mem_we),
		.wr_addr   (mem_waddr),
		.wr_data   (mem_wdata),
		.rd_a_addr (mem_addr(flg_q[FLG_B], gpr_idx)),                    // [RULE9]
		.rd_a_data (mem_rd_core),
		.rd_b_addr (mem_addr(bus_bank, paddr[4:2])),
		.rd_b_data (mem_rd_bus)
	);

	assign gpr_rdata = mem_rd_core;

	// ========================================================================
	// read data
	always_comb begin
		prdata = RST_RD;
		if (acc && !pwrite) begin
			case (sel)
				CSF_SEL_USP: begin
					prdata[WIDTH-1:0] = usp_q;
				end
				CSF_SEL_ISP: begin
					prdata[WIDTH-1:0] = isp_q;
				end
				CSF_SEL_SB: begin
					prdata[WIDTH-1:0] = sb_q;
				end
				CSF_SEL_FLG: begin
					prdata[FLAG_W-1:0] = flg_q;
				end
				CSF_SEL_ASP: begin
					prdata[WIDTH-1:0] = asp_q;
				end
				CSF_SEL_BANK: begin
					prdata[WIDTH-1:0] = mem_rd_bus;
				end
				default: begin
					prdata = RST_RD;
				end
			endcase
		end
	end

endmodule

/* File: core/csf_pkg.sv */
// Purpose: shared constants and types of the core state and flag registers
// Assumes: 32-bit APB data, 16-bit core registers, 11-bit flag register
// Notes:   offsets are byte addresses of aligned words
// ============================================================================
// package
package csf_pkg;

	// ========================================================================
	// widths
	localparam int DATA_W    = 16;
	localparam int FLAG_W    = 11;
	localparam int ADDR_W    = 12;
	localparam int BANK_REGS = 7;
	localparam int GPR_IDX_W = 3;
	localparam int MEM_AW    = 4;

	// ========================================================================
	// register offsets
	localparam logic [11:0] OFS_USP    = 12'h000;
	localparam logic [11:0] OFS_ISP    = 12'h004;
	localparam logic [11:0] OFS_SB     = 12'h008;
	localparam logic [11:0] OFS_FLG    = 12'h00C;
	localparam logic [11:0] OFS_ASP    = 12'h010;
	localparam logic [11:0] OFS_BANK0  = 12'h040;
	localparam logic [11:0] OFS_BANK1  = 12'h060;

	// ========================================================================
	// flag bit positions
	localparam int FLG_C      = 0;
	localparam int FLG_D      = 1;
	localparam int FLG_Z      = 2;
	localparam int FLG_S      = 3;
	localparam int FLG_B      = 4;
	localparam int FLG_O      = 5;
	localparam int FLG_I      = 6;
	localparam int FLG_U      = 7;
	localparam int FLG_IPL_LO = 8;
	localparam int FLG_IPL_HI = 10;

	// ========================================================================
	// general register index within a bank
	localparam logic [2:0] GPR_R0 = 3'h0;
	localparam logic [2:0] GPR_R1 = 3'h1;
	localparam logic [2:0] GPR_R2 = 3'h2;
	localparam logic [2:0] GPR_R3 = 3'h3;
	localparam logic [2:0] GPR_A0 = 3'h4;
	localparam logic [2:0] GPR_A1 = 3'h5;
	localparam logic [2:0] GPR_FB = 3'h6;

	// ========================================================================
	// values after reset
	localparam logic [15:0] RST_USP = 16'h0000;
	localparam logic [15:0] RST_ISP = 16'h0000;
	localparam logic [15:0] RST_SB  = 16'h0000;
	localparam logic [10:0] RST_FLG = 11'h000;
	localparam logic [31:0] RST_RD  = 32'h0000_0000;

	// ========================================================================
	// register select decoded from the bus address
	typedef enum logic [2:0] {
		CSF_SEL_USP  = 3'b000,
		CSF_SEL_ISP  = 3'b001,
		CSF_SEL_SB   = 3'b010,
		CSF_SEL_FLG  = 3'b011,
		CSF_SEL_ASP  = 3'b100,
		CSF_SEL_BANK = 3'b101,
		CSF_SEL_NONE = 3'b110
	} csf_sel_t;

endpackage

/* File: core/csf_bank_mem.sv */
// Purpose: storage for both general register banks
// Assumes: one write port, two read ports, read data registered
// Notes:   write and read of one word in one cycle returns the old word
`timescale 1ns/1ps
module csf_bank_mem
	import csf_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int AW    = MEM_AW
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_a_addr,
	output logic      [WIDTH-1:0] rd_a_data,
	input  wire logic [AW-1:0]    rd_b_addr,
	output logic      [WIDTH-1:0] rd_b_data
);

	// ========================================================================
	// checks
	if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
		$error("csf_bank_mem: WIDTH must be 1 to 32");
	end
	if (AW < 4) begin : g_bad_aw
		$error("csf_bank_mem: AW too small for two banks");
	end

	// ========================================================================
	// storage
	logic [WIDTH-1:0] mem_q [2**AW];
	logic [WIDTH-1:0] rd_a_q;
	logic [WIDTH-1:0] rd_b_q;

	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_a_q <= '0;
			rd_b_q <= '0;
		end else begin
			rd_a_q <= mem_q[rd_a_addr];
			rd_b_q <= mem_q[rd_b_addr];
		end
	end

	assign rd_a_data = rd_a_q;
	assign rd_b_data = rd_b_q;

endmodule

/* File: core/csf_flag_unit.sv */
// Purpose: next value of the processor flag register
// Assumes: software write and ALU update may arrive in one cycle
// Notes:   ALU result flags override the written value of the same bits
`timescale 1ns/1ps
module csf_flag_unit
	import csf_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	input  wire logic [FLAG_W-1:0] flag_q,
	input  wire logic              sw_we,
	input  wire logic [FLAG_W-1:0] sw_wdata,
	input  wire logic              alu_flag_we,
	input  wire logic [WIDTH-1:0]  alu_result,
	input  wire logic              alu_carry,
	input  wire logic              alu_overflow,
	output logic      [FLAG_W-1:0] flag_d
);

	// ========================================================================
	// checks
	if (WIDTH < 2) begin : g_bad_width
		$error("csf_flag_unit: WIDTH must be at least 2");
	end

	// ========================================================================
	// flag update
	always_comb begin
		flag_d = flag_q;
		if (sw_we) begin
			flag_d = sw_wdata;
		end
		if (alu_flag_we) begin
			flag_d[FLG_C] = alu_carry;                       // [RULE5]
			flag_d[FLG_Z] = (alu_result == '0);              // [RULE7]
			flag_d[FLG_S] = alu_result[WIDTH-1];             // [RULE8]
			flag_d[FLG_O] = alu_overflow;                    // [RULE10]
		end
	end

endmodule

/* File: sim/csf_alu_model.sv */
// Purpose: adder standing in for the arithmetic and logic unit
// Assumes: one add per go pulse, flags shown for one cycle after it
// Notes:   result and flags are registered like a real pipeline stage
`timescale 1ns/1ps
module csf_alu_model
	import csf_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              go,
	input  wire logic [DATA_W-1:0] a,
	input  wire logic [DATA_W-1:0] b,
	output logic                   flag_we,
	output logic      [DATA_W-1:0] result,
	output logic                   carry,
	output logic                   overflow
);
	logic [DATA_W:0] sum;
	assign sum = {1'b0, a} + {1'b0, b};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_we  <= 1'b0;
			result   <= 16'h0000;
			carry    <= 1'b0;
			overflow <= 1'b0;
		end else begin
			flag_we  <= go;
			result   <= sum[DATA_W-1:0];
			carry    <= sum[DATA_W];
			overflow <= (a[15] == b[15]) && (sum[15] != a[15]);
		end
	end
endmodule

/* File: sim/csf_core_regs_chk.sv */
// Purpose: port checks of the core state registers
// Assumes: bound into csf_core_regs
// Notes:   one clock domain
`timescale 1ns/1ps
module csf_core_regs_chk
	import csf_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic [ADDR_W-1:0]    paddr,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 alu_flag_we,
	input wire logic [WIDTH-1:0]     alu_result,
	input wire logic                 alu_carry,
	input wire logic                 alu_overflow,
	input wire logic                 sp_we,
	input wire logic [WIDTH-1:0]     sp_wdata,
	input wire logic [WIDTH-1:0]     active_stack_ptr,
	input wire logic [WIDTH-1:0]     static_base_reg,
	input wire logic [FLAG_W-1:0]    processor_flag_reg,
	input wire logic [GPR_IDX_W-1:0] gpr_idx,
	input wire logic                 gpr_we,
	input wire logic [WIDTH-1:0]     gpr_wdata,
	input wire logic [WIDTH-1:0]     gpr_rdata
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic bus_wr;
	logic rst_seen_q;
	assign bus_wr = psel & pwrite;
	// reset values are checked from the second edge of a reset on
	always_ff @(posedge pclk) begin
		rst_seen_q <= !presetn;
	end
	// ========================================================================
	// flags
	a_zero_flag: assert property (alu_flag_we |=>
		processor_flag_reg[FLG_Z] == ($past(alu_result) == 0))
		else $error("zero flag wrong");
	a_sign_flag: assert property (alu_flag_we |=>
		processor_flag_reg[FLG_S] == $past(alu_result[WIDTH-1]))
		else $error("sign flag wrong");
	a_carry_flag: assert property (alu_flag_we |=>
		processor_flag_reg[FLG_C] == $past(alu_carry))
		else $error("carry flag wrong");
	a_ovf_flag: assert property (alu_flag_we |=>
		processor_flag_reg[FLG_O] == $past(alu_overflow))
		else $error("overflow flag wrong");
	a_flag_hold: assert property (!alu_flag_we && !bus_wr |=>
		$stable(processor_flag_reg))
		else $error("flag register changed alone");
	a_reset_state: assert property (disable iff (1'b0)
		!presetn && rst_seen_q |-> processor_flag_reg == RST_FLG
		&& active_stack_ptr == RST_ISP && static_base_reg == RST_SB)
		else $error("reset state wrong");
	// ========================================================================
	// pointers and base
	a_sp_write: assert property (sp_we && !psel |=>
		active_stack_ptr == $past(sp_wdata))
		else $error("active pointer not written");
	a_sb_hold: assert property (!(bus_wr && paddr == OFS_SB) |=>
		$stable(static_base_reg))
		else $error("static base changed alone");
	a_asp_ro: assert property (bus_wr && penable && paddr == OFS_ASP |->
		pslverr && pready)
		else $error("active pointer write not refused");
	// ========================================================================
	// banks
	sequence s_gpr_wr;
		gpr_we && gpr_idx != 3'h7 && !psel;
	endsequence
	sequence s_gpr_hold;
		!gpr_we && $stable(gpr_idx) && !psel;
	endsequence
	a_gpr_read: assert property (s_gpr_wr ##1 s_gpr_hold |=>
		gpr_rdata == $past(gpr_wdata, 2))
		else $error("general register readback wrong");
	a_bank_stall: assert property (gpr_we && gpr_idx != 3'h7 && psel && pwrite
		&& paddr[11:6] == 6'h01 && paddr[1:0] == 2'h0 && paddr[4:2] != 3'h7 |-> !pready)
		else $error("bus bank write not held off");
endmodule
bind csf_core_regs csf_core_regs_chk #(.WIDTH(WIDTH)) i_csf_core_regs_chk (.pclk, .presetn,
	.paddr, .psel, .penable, .pwrite, .pready, .pslverr, .alu_flag_we, .alu_result,
	.alu_carry, .alu_overflow, .sp_we, .sp_wdata, .active_stack_ptr, .static_base_reg,
	.processor_flag_reg, .gpr_idx, .gpr_we, .gpr_wdata, .gpr_rdata);

/* File: sim/test_csf_core_regs.sv */
// Purpose: directed bench of the core state registers
// Assumes: bus answers whenever pready is high
// Notes:   core outputs are sampled at the falling edge, bus read data and pslverr at the rising edge
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_csf_core_regs;
	import csf_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, alu_go;
	logic        alu_flag_we, alu_carry, alu_overflow, sp_we, gpr_we;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] alu_a, alu_b, alu_result, sp_wdata, active_stack_ptr, static_base_reg;
	logic [15:0] gpr_wdata, gpr_rdata;
	logic [10:0] processor_flag_reg;
	logic [2:0]  gpr_idx;
	int          failures, n_tests;
	logic [15:0] ta [4] = '{16'h0000, 16'hFFFF, 16'h7FFF, 16'h0001};
	logic [15:0] tb [4] = '{16'h0000, 16'h0001, 16'h0001, 16'h0002};
	logic [3:0]  tf [4] = '{4'h2, 4'h3, 4'hC, 4'h0};
	logic [3:0]  fl;
	csf_core_regs i_csf_core_regs (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .alu_flag_we, .alu_result, .alu_carry,
		.alu_overflow, .sp_we, .sp_wdata, .active_stack_ptr, .static_base_reg,
		.processor_flag_reg, .gpr_idx, .gpr_we, .gpr_wdata, .gpr_rdata);
	csf_alu_model i_csf_alu_model (.pclk, .presetn, .go(alu_go), .a(alu_a), .b(alu_b),
		.flag_we(alu_flag_we), .result(alu_result), .carry(alu_carry),
		.overflow(alu_overflow));
	// ========================================================================
	// tasks
	task print_verdict;
		if (failures == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ========================================================================
	// tests
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (3000) @(posedge pclk);
		failures++;
		print_verdict();
	end
	initial begin
		{presetn, psel, penable, pwrite, alu_go, sp_we, gpr_we} = '0;
		{paddr, pwdata, alu_a, alu_b, sp_wdata, gpr_wdata, gpr_idx} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 12'(4 * i), 32'h0);
			`CHK(rd, RST_RD)
		end
		apb(1'b1, OFS_USP, 32'h1234);
		apb(1'b1, OFS_ISP, 32'hABCD);
		apb(1'b1, OFS_SB, 32'h5A5A);
		@(negedge pclk);
		`CHK(static_base_reg, 16'h5A5A)
		`CHK(active_stack_ptr, 16'hABCD)
		apb(1'b1, OFS_FLG, 32'hFFFF_FFFD);
		apb(1'b0, OFS_FLG, 32'h0);
		`CHK(rd, 32'h7FD)
		apb(1'b0, OFS_ASP, 32'h0);
		`CHK(rd, 32'h1234)
		apb(1'b1, OFS_ASP, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b0, 12'h020, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b1, OFS_FLG, 32'h0);
		@(posedge pclk);
		sp_we <= 1'b1;
		sp_wdata <= 16'h0F0F;
		@(posedge pclk);
		sp_we <= 1'b0;
		apb(1'b0, OFS_ISP, 32'h0);
		`CHK(rd, 32'h0F0F)
		apb(1'b0, OFS_USP, 32'h0);
		`CHK(rd, 32'h1234)
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			alu_go <= 1'b1;
			alu_a <= ta[i];
			alu_b <= tb[i];
			@(posedge pclk);
			alu_go <= 1'b0;
			@(posedge pclk);
			@(negedge pclk);
			`CHK(processor_flag_reg & 11'h7D2, 11'h000)
			fl = {processor_flag_reg[FLG_O], processor_flag_reg[FLG_S],
				processor_flag_reg[FLG_Z], processor_flag_reg[FLG_C]};
			`CHK(fl, tf[i])
		end
		for (int b = 0; b < 2; b++) begin
			apb(1'b1, OFS_FLG, 32'(b << FLG_B));
			for (int i = 0; i < 7; i++) begin
				@(posedge pclk);
				gpr_idx <= 3'(i);
				gpr_we <= 1'b1;
				gpr_wdata <= 16'(16'h1000 * (b + 1) + i);
				@(posedge pclk);
				gpr_we <= 1'b0;
			end
		end
		@(posedge pclk);
		gpr_idx <= GPR_R2;
		@(posedge pclk);
		@(negedge pclk);
		`CHK(gpr_rdata, 16'h2002)
		for (int b = 0; b < 2; b++) begin
			for (int i = 0; i < 7; i++) begin
				apb(1'b0, (b == 0 ? OFS_BANK0 : OFS_BANK1) + 12'(4 * i), 32'h0);
				`CHK(rd, 32'(16'h1000 * (b + 1) + i))
			end
		end
		// bus bank write held off while the core writes the bank
		fork
			apb(1'b1, OFS_BANK1 + 12'h00C, 32'h0000_BEEF);
			begin
				gpr_idx <= GPR_A0;
				gpr_we <= 1'b1;
				gpr_wdata <= 16'hCAFE;
				repeat (3) @(posedge pclk);
				gpr_we <= 1'b0;
			end
		join
		apb(1'b0, OFS_BANK1 + 12'h00C, 32'h0);
		`CHK(rd, 32'h0000_BEEF)
		apb(1'b0, OFS_BANK1 + 12'h010, 32'h0);
		`CHK(rd, 32'h0000_CAFE)
		// reset in mid-run
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_FLG, 32'h0);
		`CHK(rd, RST_RD)
		@(negedge pclk);
		`CHK(static_base_reg, RST_SB)
		`CHK(active_stack_ptr, RST_ISP)
		print_verdict();
	end
endmodule
